// *** core/sce_err_handler.sv ***
// Error detection, reporting and recovery for the single-wire link.
// Assumes a field receiver on clk delivers one-cycle event pulses; the
// raw link pin arrives asynchronously and is synchronised here.
//
// Notes on behaviour
// - Stop bit low: flag 0, error, abort
// - Timeout sets flag 5, go standby
// - Timeout keeps portions already committed
// - Write checksum bad: flag 4, error
// - Drop failing portion, keep earlier good
// - Field errors enter error; R/W data exempt
// - Long high pin: error returns standby
// - Flags stay set until register read
// - One-byte read of register clears flags
// - Multi-byte read leaves flags set
// - Gap over three fields is timeout
// - Nonzero R/W bits 5:1 set flag 6
// - Header, parity faults set flags 1-3
`timescale 1ns/1ps
`include "sce_cfg.svh"
module sce_err_handler #(
   parameter int FIELD_CYCLES = `SCE_FIELD_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic comm_pin,
   input wire logic field_evt,
   input wire logic hdr_ok,
   input wire logic hdr_bad,
   input wire logic stop_low,
   input wire logic rw_parity_bad,
   input wire logic len_parity_bad,
   input wire logic rw_field_vld,
   input wire logic [7:0] rw_field,
   input wire logic is_write,
   input wire logic chk_good,
   input wire logic chk_bad,
   input wire logic xfer_done,
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic [7:0] rd_len,
   output sce_pkg::sce_mode_t mode,
   output logic [`SCE_ERR_W-1:0] comm_error_flags,
   output logic terminate_pulse,
   output logic nullify_pulse,
   output logic commit_pulse,
   output logic [7:0] rd_data,
   output logic rd_valid
);
   import sce_pkg::*;

   // ==========================================================
   // Elaboration check
   if (FIELD_CYCLES < 1) begin : g_bad_field
      $error("sce_err_handler: FIELD_CYCLES must be at least 1");
   end

   // ==========================================================
   // Pin synchroniser
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_meta_next;
   logic pin_sync_next;

   // Pin idles high; first stage is read only by the second
   always_comb begin
      pin_meta_next = comm_pin;
      pin_sync_next = pin_meta_reg;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
      end else if (ce) begin
         pin_meta_reg <= pin_meta_next;
         pin_sync_reg <= pin_sync_next;
      end
   end

   // ==========================================================
   // Duration timers
   sce_mode_t mode_reg;
   sce_mode_t mode_next;
   sce_tmr_if gap_if ();
   sce_tmr_if idle_if ();

   // Gap timer restarts on every field boundary while communicating
   assign gap_if.run = (mode_reg == SCE_COMM) && !field_evt;
   // Idle timer only counts an unbroken high level in error mode
   assign idle_if.run = (mode_reg == SCE_ERROR) && pin_sync_reg;

   sce_field_timer #(
      .LIMIT(`SCE_GAP_FIELDS * FIELD_CYCLES)
   ) u_gap_tmr (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .t(gap_if.tmr)
   );

   sce_field_timer #(
      .LIMIT(`SCE_IDLE_FIELDS * FIELD_CYCLES)
   ) u_idle_tmr (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .t(idle_if.tmr)
   );

   // ==========================================================
   // Error detection
   logic in_comm;
   logic hdr_seen;
   logic fault;
   logic timeout;
   logic rw_data_err;
   logic [`SCE_ERR_W-1:0] flag_set;

   // Events outside communication are ignored except a header attempt in standby
   always_comb begin
      in_comm = mode_reg == SCE_COMM;
      hdr_seen = (mode_reg == SCE_STANDBY) || in_comm;
      timeout = in_comm && gap_if.expired;
      rw_data_err = in_comm && rw_field_vld && (|rw_field[5:1]);
      flag_set = '0;
      flag_set[`SCE_BIT_FRAME] = in_comm && stop_low;
      flag_set[`SCE_BIT_HDR] = hdr_seen && hdr_bad;
      flag_set[`SCE_BIT_RWPAR] = in_comm && rw_parity_bad;
      flag_set[`SCE_BIT_LENPAR] = in_comm && len_parity_bad;
      flag_set[`SCE_BIT_CHK] = in_comm && is_write && chk_bad;
      flag_set[`SCE_BIT_TOUT] = timeout;
      flag_set[`SCE_BIT_RWDATA] = rw_data_err;
      // Every fault but the timeout and R/W data ones forces error mode
      fault = |flag_set[`SCE_BIT_CHK:`SCE_BIT_FRAME];
   end

   // ==========================================================
   // Mode machine
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         SCE_STANDBY: begin
            if (fault) begin
               mode_next = SCE_ERROR;
            end else if (hdr_ok) begin
               mode_next = SCE_COMM;
            end
         end
         SCE_COMM: begin
            // Faults outrank a coincident timeout or end of transfer
            if (fault) begin
               mode_next = SCE_ERROR;
            end else if (timeout) begin
               mode_next = SCE_STANDBY;
            end else if (xfer_done) begin
               mode_next = SCE_STANDBY;
            end
         end
         SCE_ERROR: begin
            // Recovery ignores the flag contents on purpose
            if (idle_if.expired) begin
               mode_next = SCE_STANDBY;
            end
         end
         default: begin
            mode_next = SCE_STANDBY;
         end
      endcase
   end

   // ==========================================================
   // Data disposition
   logic rw_null_reg;
   logic rw_null_next;
   logic term_next;
   logic null_next;
   logic commit_next;

   // A bad R/W field poisons later write portions of the transfer
   always_comb begin
      rw_null_next = rw_null_reg;
      if (!in_comm || mode_next != SCE_COMM) begin
         rw_null_next = 1'b0;
      end else if (rw_data_err) begin
         rw_null_next = 1'b1;
      end
      term_next = in_comm && (fault || timeout);
      // Only the portion in flight is nullified; committed ones stay
      null_next = (in_comm && fault) || (rw_data_err && is_write);
      // Good portions commit at once, so a later timeout keeps them
      commit_next = in_comm && is_write && chk_good && !fault
         && !rw_null_reg && !rw_data_err;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mode_reg <= SCE_STANDBY;
         rw_null_reg <= 1'b0;
         terminate_pulse <= 1'b0;
         nullify_pulse <= 1'b0;
         commit_pulse <= 1'b0;
      end else if (ce) begin
         mode_reg <= mode_next;
         rw_null_reg <= rw_null_next;
         terminate_pulse <= term_next;
         nullify_pulse <= null_next;
         commit_pulse <= commit_next;
      end
   end

   assign mode = mode_reg;

   // ==========================================================
   // Error register and read port
   logic [`SCE_ERR_W-1:0] flags_reg;
   logic [`SCE_ERR_W-1:0] flags_next;
   logic [7:0] rd_data_next;
   logic rd_valid_next;
   logic rd_hit;
   logic rd_clear;

   // Set wins over a read clear in the same cycle
   always_comb begin
      rd_hit = rd_req && (mode_reg == SCE_COMM) && (rd_addr == `SCE_ERR_ADDR);
      rd_clear = rd_hit && (rd_len == `SCE_RD_LEN_ONE);
      flags_next = (rd_clear ? `SCE_FLAGS_RST : flags_reg) | flag_set;
      rd_valid_next = rd_req && (mode_reg == SCE_COMM);
      // Other addresses belong to other blocks and read as zero here
      rd_data_next = rd_hit ? {1'b0, flags_reg} : 8'h00;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_reg <= `SCE_FLAGS_RST;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else if (ce) begin
         flags_reg <= flags_next;
         rd_data <= rd_data_next;
         rd_valid <= rd_valid_next;
      end
   end

   assign comm_error_flags = flags_reg;
endmodule // sce_err_handler

// *** core/sce_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the
// serial link error handler. Definitions only; included by bare name.
`ifndef SCE_CFG_SVH
`define SCE_CFG_SVH

// ==========================================================
// Register map
`define SCE_ERR_ADDR 16'h0219
`define SCE_ERR_W 7
`define SCE_FLAGS_RST 7'h00
`define SCE_RD_LEN_ONE 8'h01

// ==========================================================
// Flag positions in the error register
`define SCE_BIT_FRAME 0
`define SCE_BIT_HDR 1
`define SCE_BIT_RWPAR 2
`define SCE_BIT_LENPAR 3
`define SCE_BIT_CHK 4
`define SCE_BIT_TOUT 5
`define SCE_BIT_RWDATA 6

// ==========================================================
// Timing: gap and idle in field durations, field length in clock cycles
`define SCE_GAP_FIELDS 3
`define SCE_IDLE_FIELDS 4
`define SCE_FIELD_CYCLES_DEF 2000

`endif

// *** core/sce_pkg.sv ***
// Types shared by the serial link error handler.
// Assumes nothing of its surroundings.
package sce_pkg;
   // Link modes of the device
   typedef enum logic [1:0] {
      SCE_STANDBY,
      SCE_COMM,
      SCE_ERROR
   } sce_mode_t;
endpackage

// *** core/sce_tmr_if.sv ***
// Carrier between the error handler and one of its duration timers.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface sce_tmr_if;
   logic run;
   logic expired;
   modport ctl (output run, input expired);
   modport tmr (input run, output expired);
endinterface

// *** core/sce_field_timer.sv ***
// Duration timer: counts while run is high, restarts when it drops,
// flags once the count has gone past LIMIT cycles.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps
module sce_field_timer #(
   parameter int LIMIT = 6000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   sce_tmr_if.tmr t
);
   localparam int CW = $clog2(LIMIT + 2);
   localparam logic [CW-1:0] LIM = CW'(LIMIT);

   // ==========================================================
   // Elaboration check
   if (LIMIT < 1) begin : g_bad_limit
      $error("sce_field_timer: LIMIT must be at least 1");
   end

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   // Saturating count; strictly longer than LIMIT counts as expiry
   always_comb begin
      cnt_next = cnt_reg;
      if (!t.run) begin
         cnt_next = '0;
      end else if (cnt_reg <= LIM) begin
         cnt_next = cnt_reg + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end

   assign t.expired = cnt_reg > LIM;
endmodule // sce_field_timer

// *** verif/sce_err_handler_props.sv ***
// Checker of the link error handler, bound to its top module.
// Assumes the bench keeps ce high.
`timescale 1ns/1ps
module sce_err_props
   import sce_pkg::*;
#(
   parameter int FIELD_CYCLES = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic comm_pin,
   input wire logic field_evt,
   input wire logic hdr_bad,
   input wire logic stop_low,
   input wire logic rw_parity_bad,
   input wire logic len_parity_bad,
   input wire logic rw_field_vld,
   input wire logic is_write,
   input wire logic chk_bad,
   input wire logic xfer_done,
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic [7:0] rd_len,
   input sce_pkg::sce_mode_t mode,
   input wire logic [6:0] comm_error_flags,
   input wire logic terminate_pulse,
   input wire logic nullify_pulse,
   input wire logic commit_pulse,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   int hi_cnt;
   int gap_cnt;
   logic comm;
   logic clr;
   logic pin_d1;
   logic pin_d2;
   // ==========
   // Run lengths; pin delayed two stages, as the input synchroniser does,
   // so a pin that drops just before recovery cannot fool the count
   assign comm = mode == SCE_COMM;
   assign clr = rd_req && comm && rd_addr == 16'h0219 && rd_len == 8'h01;
   always_ff @(posedge clk) begin
      pin_d1 <= comm_pin;
      pin_d2 <= pin_d1;
      hi_cnt <= (rst_n && mode == SCE_ERROR && pin_d2) ? hi_cnt + 1 : 0;
      gap_cnt <= (rst_n && comm && !field_evt) ? gap_cnt + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========
   // Faults, flags and timers
   a_frame_abort: assert property (comm && stop_low |=> comm_error_flags[0] &&
      mode == SCE_ERROR && terminate_pulse && nullify_pulse) else $error("frame");
   a_chk_abort: assert property (comm && chk_bad && is_write |=>
      comm_error_flags[4] && mode == SCE_ERROR && nullify_pulse && !commit_pulse)
      else $error("checksum");
   a_hdr_fault: assert property (hdr_bad && mode != SCE_ERROR |=>
      comm_error_flags[1] && mode == SCE_ERROR) else $error("header");
   a_flags_sticky: assert property (!clr |=> (comm_error_flags &
      $past(comm_error_flags)) == $past(comm_error_flags)) else $error("sticky");
   a_read_clear: assert property (clr |=>
      rd_valid && rd_data == {1'b0, $past(comm_error_flags)}) else $error("read");
   a_clear_empty: assert property (clr && !stop_low && !hdr_bad && !rw_parity_bad &&
      !len_parity_bad && !chk_bad && !rw_field_vld && gap_cnt < 3 * FIELD_CYCLES |=>
      comm_error_flags == 7'h00) else $error("clear");
   a_tout_standby: assert property ($past(comm) && mode == SCE_STANDBY &&
      !$past(xfer_done) |-> comm_error_flags[5] && terminate_pulse &&
      $past(gap_cnt) >= 3 * FIELD_CYCLES) else $error("timeout");
   a_tout_bound: assert property (comm |->
      gap_cnt <= 3 * FIELD_CYCLES + 4) else $error("gap");
   a_recover_late: assert property ($past(mode) == SCE_ERROR &&
      mode == SCE_STANDBY |-> $past(hi_cnt) >= 4 * FIELD_CYCLES) else $error("early");
   a_recover_bound: assert property (mode == SCE_ERROR |->
      hi_cnt <= 4 * FIELD_CYCLES + 6) else $error("stuck");
   c_recover: cover property (mode == SCE_ERROR ##1 mode == SCE_STANDBY);
   c_commit: cover property (commit_pulse);
   c_read: cover property (rd_valid && rd_data != 8'h00);
endmodule // sce_err_props
bind sce_err_handler sce_err_props #(.FIELD_CYCLES(FIELD_CYCLES)) i_chk (
   .clk(clk),
   .rst_n(rst_n),
   .comm_pin(comm_pin),
   .field_evt(field_evt),
   .hdr_bad(hdr_bad),
   .stop_low(stop_low),
   .rw_parity_bad(rw_parity_bad),
   .len_parity_bad(len_parity_bad),
   .rw_field_vld(rw_field_vld),
   .is_write(is_write),
   .chk_bad(chk_bad),
   .xfer_done(xfer_done),
   .rd_req(rd_req),
   .rd_addr(rd_addr),
   .rd_len(rd_len),
   .mode(mode),
   .comm_error_flags(comm_error_flags),
   .terminate_pulse(terminate_pulse),
   .nullify_pulse(nullify_pulse),
   .commit_pulse(commit_pulse),
   .rd_data(rd_data),
   .rd_valid(rd_valid)
);

// *** verif/sce_master_model.sv ***
// Far-side master: owns the link pin between frames.
// Assumes the bench asks for low only to disturb recovery.
`timescale 1ns/1ps
module sce_master_model (
   input wire logic pull_low,
   output logic pin
);
   // Pulled up, so a master that lets go leaves the pin high
   assign pin = !pull_low;
endmodule // sce_master_model

// *** verif/tb_serial_comm_error_handler.sv ***
// Self-checking bench of the link error handler.
// Assumes design, model and checker are compiled first.
`timescale 1ns/1ps
module tb_serial_comm_error_handler;
   import sce_pkg::*;
   localparam logic [9:0] FLD = 10'h001, HOK = 10'h002, HBAD = 10'h004, STOP = 10'h008;
   localparam logic [9:0] RWP = 10'h010, LENP = 10'h020, RWV = 10'h040, CGD = 10'h080;
   localparam logic [9:0] CBD = 10'h100, DONE = 10'h200;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic lo = 1'b0;
   logic pin;
   logic [9:0] ev = 10'h000;
   logic [7:0] rw_field = 8'h00;
   logic is_write = 1'b1;
   logic rd_req = 1'b0;
   logic [15:0] rd_addr = 16'h0000;
   logic [7:0] rd_len = 8'h00;
   sce_mode_t mode;
   logic [6:0] comm_error_flags;
   logic terminate_pulse;
   logic nullify_pulse;
   logic commit_pulse;
   logic [7:0] rd_data;
   logic rd_valid;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   always #2.5 clk = ~clk;
   sce_master_model i_mst (.pull_low(lo), .pin(pin));
   sce_err_handler #(.FIELD_CYCLES(4)) i_dut (
      .clk(clk),
      .rst_n(rst_n),
      .ce(1'b1),
      .comm_pin(pin),
      .field_evt(ev[0]),
      .hdr_ok(ev[1]),
      .hdr_bad(ev[2]),
      .stop_low(ev[3]),
      .rw_parity_bad(ev[4]),
      .len_parity_bad(ev[5]),
      .rw_field_vld(ev[6]),
      .rw_field(rw_field),
      .is_write(is_write),
      .chk_good(ev[7]),
      .chk_bad(ev[8]),
      .xfer_done(ev[9]),
      .rd_req(rd_req),
      .rd_addr(rd_addr),
      .rd_len(rd_len),
      .mode(mode),
      .comm_error_flags(comm_error_flags),
      .terminate_pulse(terminate_pulse),
      .nullify_pulse(nullify_pulse),
      .commit_pulse(commit_pulse),
      .rd_data(rd_data),
      .rd_valid(rd_valid)
   );
   // ==========
   // Access tasks and compares
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ckf(input logic [7:0] exp);
      chk({1'b0, comm_error_flags}, exp);
   endtask
   task automatic ckm(input sce_mode_t m);
      chk({6'h00, mode}, {6'h00, m});
   endtask
   // Event pulse for one cycle, then look just after the answering edge
   task automatic fire(input logic [9:0] e);
      @(posedge clk) ev <= e;
      @(posedge clk) ev <= 10'h000;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] n, input logic [7:0] exp);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_addr <= a;
      rd_len <= n;
      @(posedge clk);
      rd_req <= 1'b0;
      #1;
      chk({7'h00, rd_valid}, 8'h01);
      chk(rd_data, exp);
   endtask
   // Bounded wait for a mode change
   task automatic wait_mode(input sce_mode_t m);
      for (int i = 0; i < 60 && mode !== m; i++) begin
         @(posedge clk);
         #1;
      end
      ckm(m);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Ceiling far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict;
      end
   end
   // ==========
   // Tests
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      ckf(8'h00);
      fire(HOK);
      fire(STOP);
      ckf(8'h01);
      chk({6'h00, terminate_pulse, nullify_pulse}, 8'h03);
      fire(HOK);
      ckm(SCE_ERROR);
      wait_mode(SCE_STANDBY);
      ckf(8'h01);
      fire(HOK);
      rd(16'h0219, 8'h01, 8'h01);
      rd(16'h0219, 8'h01, 8'h00);
      fire(DONE);
      $display("test 1 done");
      fire(HOK);
      fire(FLD | CGD);
      chk({7'h00, commit_pulse}, 8'h01);
      fire(FLD | CBD);
      ckf(8'h10);
      chk({6'h00, nullify_pulse, commit_pulse}, 8'h02);
      @(posedge clk) lo <= 1'b1;
      repeat (30) @(posedge clk);
      lo <= 1'b0;
      #1;
      ckm(SCE_ERROR);
      wait_mode(SCE_STANDBY);
      $display("test 2 done");
      fire(HOK);
      fire(FLD | CGD);
      chk({7'h00, commit_pulse}, 8'h01);
      wait_mode(SCE_STANDBY);
      ckf(8'h30);
      fire(HOK);
      rd(16'h0219, 8'h02, 8'h30);
      rd(16'h0218, 8'h01, 8'h00);
      rd(16'h0219, 8'h01, 8'h30);
      ckf(8'h00);
      fire(DONE);
      $display("test 3 done");
      @(posedge clk) rw_field <= 8'h02;
      fire(HOK);
      fire(FLD | RWV);
      ckf(8'h40);
      ckm(SCE_COMM);
      fire(FLD | CGD);
      chk({7'h00, commit_pulse}, 8'h00);
      fire(LENP);
      ckf(8'h48);
      wait_mode(SCE_STANDBY);
      fire(HBAD);
      ckf(8'h4a);
      wait_mode(SCE_STANDBY);
      fire(HOK);
      fire(RWP);
      ckf(8'h4e);
      wait_mode(SCE_STANDBY);
      // A register read outside communication is refused and clears nothing
      @(posedge clk) rd_req <= 1'b1;
      rd_addr <= 16'h0219;
      rd_len <= 8'h01;
      @(posedge clk) rd_req <= 1'b0;
      #1;
      chk({7'h00, rd_valid}, 8'h00);
      ckf(8'h4e);
      fire(HOK);
      rd(16'h0219, 8'h01, 8'h4e);
      fire(DONE);
      $display("test 4 done");
      // Read transfer: bad checksum and bad R/W bits neither abort nor nullify
      @(posedge clk) is_write <= 1'b0;
      fire(HOK);
      fire(FLD | RWV | CBD);
      ckf(8'h40);
      chk({6'h00, nullify_pulse, terminate_pulse}, 8'h00);
      ckm(SCE_COMM);
      fire(DONE);
      $display("test 5 done");
      print_verdict;
   end
endmodule // tb_serial_comm_error_handler
